//--- rtl/wake_event_indirect_regs.sv
// wake-event register bank reached through the indirect control and data registers
module wake_event_indirect_regs
  import wake_event_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire reg_req_s REG_REQ_I,
  input wire wake_ev_s [PORT_COUNT-1:0] WAKE_EV_I,
  output logic [7:0] REG_RDATA_O,
  output logic WAKE_O
);

  // ==========================================================================
  // decoding helpers

  // true when the first control byte selects the wake-event function
  function automatic logic is_wake_fn(input logic [7:0] c0);
    return c0[FN_MSB:FN_LSB] == FN_WAKE;
  endfunction

  // true when the select nibble names one of the ports
  function automatic logic is_port(input logic [3:0] sel);
    return (sel != SEL_GLOBAL) && (sel <= SEL_LAST_PORT);
  endfunction

  // byte of a word at an offset, most significant byte first
  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] off);
    logic [7:0] b;
    b = BYTE_RESET;
    case (off)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      2'h3: b = w[7:0];
      default: b = BYTE_RESET;
    endcase
    return b;
  endfunction

  // ==========================================================================
  // state
  logic [7:0] ctrl0_q, ctrl0_d;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [7:0] data_q, data_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] glb_q, glb_d;
  logic [PORT_COUNT-1:0][2:0] flags_q, flags_d;
  logic [PORT_COUNT-1:0][2:0] mask_q, mask_d;
  logic [PORT_COUNT-1:0][2:0] clr_w;
  logic wake_q, wake_d;
  logic [3:0] sel_w;
  logic [1:0] psel_w;
  logic [31:0] word_w;
  logic [7:0] rbyte_w;
  logic wr_c0, wr_c1, wr_data, trig_rd, do_wr;
  logic hit_w, en_w, pol_w;

  // ==========================================================================
  // access decode and the selected word
  always_comb begin
    sel_w = ctrl0_q[3:0];
    psel_w = 2'(sel_w - 4'h1);
    wr_c0 = REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_CTRL0);
    wr_c1 = REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_CTRL1);
    wr_data = REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_DATA);
    // a second control write in read mode triggers the fetch
    trig_rd = wr_c1 && is_wake_fn(ctrl0_q) && ctrl0_q[OP_READ_BIT];
    // a data write in write mode lands in the selected byte
    do_wr = wr_data && is_wake_fn(ctrl0_q) && !ctrl0_q[OP_READ_BIT];
    // word for the offset being triggered, reserved bits as zero
    word_w = 32'h0;
    if (REG_REQ_I.wdata[7:3] == 5'h0) begin
      if (sel_w == SEL_GLOBAL) begin
        if (REG_REQ_I.wdata <= OFF_WORD_LAST) begin
          word_w = {30'h0, glb_q};
        end
      end else if (is_port(sel_w)) begin
        if (REG_REQ_I.wdata[OFF_MASK_BIT]) begin
          word_w = {29'h0, mask_q[psel_w]};
        end else begin
          word_w = {29'h0, flags_q[psel_w]};
        end
      end
    end
    rbyte_w = byte_of(word_w, REG_REQ_I.wdata[1:0]);
  end

  // ==========================================================================
  // indirect control, data and read-back registers
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    data_d = data_q;
    rdata_d = rdata_q;
    if (wr_c0) begin
      ctrl0_d = REG_REQ_I.wdata;
    end
    if (wr_c1) begin
      ctrl1_d = REG_REQ_I.wdata;
    end
    if (trig_rd) begin
      data_d = rbyte_w;
    end else if (wr_data) begin
      data_d = REG_REQ_I.wdata;
    end
    if (REG_REQ_I.rd) begin
      case (REG_REQ_I.addr)
        ADDR_CTRL0: rdata_d = ctrl0_q;
        ADDR_CTRL1: rdata_d = ctrl1_q;
        ADDR_DATA: rdata_d = data_q;
        default: rdata_d = BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl0_q <= BYTE_RESET;
      ctrl1_q <= BYTE_RESET;
      data_q <= BYTE_RESET;
      rdata_q <= BYTE_RESET;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // global control word, written only through its last byte
  always_comb begin
    glb_d = glb_q;
    if (do_wr && (sel_w == SEL_GLOBAL) && (ctrl1_q == OFF_WORD_LAST)) begin
      glb_d = REG_REQ_I.wdata[1:0];
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      glb_q <= GLB_RESET;
    end else begin
      glb_q <= glb_d;
    end
  end

  // ==========================================================================
  // per-port sticky flags and masks
  genvar gp;
  generate
    for (gp = 0; gp < PORT_COUNT; gp++) begin : g_port
      logic port_sel;
      assign port_sel = is_port(sel_w) && (psel_w == 2'(gp));
      always_comb begin
        clr_w[gp] = 3'h0;
        mask_d[gp] = mask_q[gp];
        if (do_wr && port_sel && (ctrl1_q == OFF_WORD_LAST)) begin
          clr_w[gp] = REG_REQ_I.wdata[2:0];
        end
        if (do_wr && port_sel && (ctrl1_q == OFF_MASK_LAST)) begin
          mask_d[gp] = REG_REQ_I.wdata[2:0];
        end
        // a new event wins over a clear in the same cycle
        flags_d[gp] = (flags_q[gp] & ~clr_w[gp]) | WAKE_EV_I[gp];
      end
      always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
          flags_q[gp] <= EV_RESET;
          mask_q[gp] <= EV_RESET;
        end else begin
          flags_q[gp] <= flags_d[gp];
          mask_q[gp] <= mask_d[gp];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // wake pin: inactive level is the inverse of the chosen polarity
  always_comb begin
    en_w = glb_q[GLB_EN_BIT];
    pol_w = glb_q[GLB_POL_BIT];
    hit_w = |(flags_q & mask_q);
    wake_d = (en_w && hit_w) ? pol_w : !pol_w;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wake_q <= 1'b1; // disabled and active-low after reset
    end else begin
      wake_q <= wake_d;
    end
  end

  assign REG_RDATA_O = rdata_q;
  assign WAKE_O = wake_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  // each property looks one edge past its trigger, so that it sees a
  // registered value, at an output or inside the block, and not the logic cone behind it;
  // all of them stay quiet while reset is applied

  // wake pin against enable, polarity and masked-in flags
  a_wake_disabled: assert property (!en_w |=> WAKE_O == !$past(pol_w))
    else $error("wake pin active while disabled");
  a_wake_asserted: assert property (en_w && hit_w |=> WAKE_O == $past(pol_w))
    else $error("wake pin not at asserted level");
  a_mask_blocks: assert property (en_w && !hit_w |=> WAKE_O == !$past(pol_w))
    else $error("wake pin asserted with no masked-in flag");

  // indirect read path and refused selections
  a_reserved_zero: assert property (trig_rd && (sel_w == SEL_GLOBAL)
      && (REG_REQ_I.wdata < OFF_WORD_LAST) |=> data_q == BYTE_RESET)
    else $error("reserved global byte not zero");
  a_bad_port: assert property (trig_rd && (sel_w > SEL_LAST_PORT) |=> data_q == 8'h00)
    else $error("unmapped port select returned data");
  a_unmapped_read: assert property (REG_REQ_I.rd
      && (REG_REQ_I.addr != ADDR_CTRL0) && (REG_REQ_I.addr != ADDR_CTRL1)
      && (REG_REQ_I.addr != ADDR_DATA) |=> REG_RDATA_O == BYTE_RESET)
    else $error("unmapped read not zero");
  a_data_readback: assert property (trig_rd
      ##1 (REG_REQ_I.rd && REG_REQ_I.addr == ADDR_DATA && !REG_REQ_I.wr)
      |=> REG_RDATA_O == $past(data_q))
    else $error("indirect read byte not returned");
  // the control bytes read back as last written
  a_ctrl0_readback: assert property (REG_REQ_I.rd && (REG_REQ_I.addr == ADDR_CTRL0)
      |=> REG_RDATA_O == $past(ctrl0_q))
    else $error("first control byte not returned");
  a_ctrl1_readback: assert property (REG_REQ_I.rd && (REG_REQ_I.addr == ADDR_CTRL1)
      |=> REG_RDATA_O == $past(ctrl1_q))
    else $error("offset byte not returned");
  // read data stands until the next read strobe
  a_rdata_hold: assert property (!REG_REQ_I.rd |=> $stable(REG_RDATA_O))
    else $error("read data changed without a read");
  // the data byte moves only on a trigger or a data write
  a_data_hold: assert property (!trig_rd && !wr_data |=> $stable(data_q))
    else $error("data byte changed without an access");

  // write paths of the global and mask words
  a_glb_write: assert property (do_wr && (sel_w == SEL_GLOBAL)
      && (ctrl1_q == OFF_WORD_LAST) |=> glb_q == $past(REG_REQ_I.wdata[1:0]))
    else $error("global control write lost");
  a_glb_reserved: assert property (do_wr && (sel_w == SEL_GLOBAL)
      && (ctrl1_q != OFF_WORD_LAST) |=> $stable(glb_q))
    else $error("reserved global byte write took effect");
  // a data write with the read bit set leaves the global word and the masks alone
  a_read_mode_wr: assert property (wr_data && ctrl0_q[OP_READ_BIT]
      |=> $stable(glb_q) && $stable(mask_q))
    else $error("data write in read mode changed a wake register");
  // a select above the last port must not alias onto a real port
  a_bad_port_wr: assert property (do_wr && (sel_w > SEL_LAST_PORT)
      |=> $stable(glb_q) && $stable(mask_q))
    else $error("write to an unmapped port took effect");

  generate
    for (gp = 0; gp < PORT_COUNT; gp++) begin : g_chk
      a_magic_sticky: assert property (WAKE_EV_I[gp].magic |=> flags_q[gp][EV_MAGIC_BIT])
        else $error("magic packet flag not set");
      a_link_sticky: assert property (WAKE_EV_I[gp].link_up |=> flags_q[gp][EV_LINK_BIT])
        else $error("link-up flag not set");
      a_energy_sticky: assert property (WAKE_EV_I[gp].energy
          |=> flags_q[gp][EV_ENERGY_BIT])
        else $error("energy flag not set");
      a_flag_hold: assert property (flags_q[gp][EV_MAGIC_BIT]
          && !clr_w[gp][EV_MAGIC_BIT] |=> flags_q[gp][EV_MAGIC_BIT])
        else $error("magic flag dropped without a clear");
      a_flag_clear: assert property (clr_w[gp][EV_LINK_BIT]
          && !WAKE_EV_I[gp].link_up |=> !flags_q[gp][EV_LINK_BIT])
        else $error("link-up flag not cleared by a written one");
      // write-1 clears and holds of the remaining flags
      a_magic_clear: assert property (clr_w[gp][EV_MAGIC_BIT] && !WAKE_EV_I[gp].magic
          |=> !flags_q[gp][EV_MAGIC_BIT])
        else $error("magic flag not cleared by a written one");
      a_energy_clear: assert property (clr_w[gp][EV_ENERGY_BIT]
          && !WAKE_EV_I[gp].energy |=> !flags_q[gp][EV_ENERGY_BIT])
        else $error("energy flag not cleared by a written one");
      a_link_hold: assert property (flags_q[gp][EV_LINK_BIT] && !clr_w[gp][EV_LINK_BIT]
          |=> flags_q[gp][EV_LINK_BIT])
        else $error("link-up flag dropped without a clear");
      a_energy_hold: assert property (flags_q[gp][EV_ENERGY_BIT]
          && !clr_w[gp][EV_ENERGY_BIT] |=> flags_q[gp][EV_ENERGY_BIT])
        else $error("energy flag dropped without a clear");
      // the last mask byte is the only way into a port's mask
      a_mask_write: assert property (do_wr && is_port(sel_w) && (psel_w == 2'(gp))
          && (ctrl1_q == OFF_MASK_LAST) |=> mask_q[gp] == $past(REG_REQ_I.wdata[2:0]))
        else $error("mask write lost");
      a_mask_stable: assert property (!(do_wr && is_port(sel_w) && (psel_w == 2'(gp))
          && (ctrl1_q == OFF_MASK_LAST)) |=> $stable(mask_q[gp]))
        else $error("mask changed without a write to its last byte");
    end
  endgenerate

  // main scenarios
  c_read_trigger: cover property (trig_rd && is_port(sel_w) ##1 REG_REQ_I.rd);
  c_wake_raise: cover property (en_w && !hit_w ##1 hit_w ##1 WAKE_O == pol_w);
  c_clear_flag: cover property (|clr_w[0] ##1 flags_q[0] == 3'h0);
  c_set_beats_clear: cover property (|(clr_w[1] & WAKE_EV_I[1]));
  c_active_low: cover property (en_w && !pol_w && hit_w ##1 !WAKE_O);

endmodule

//--- rtl/wake_event_pkg.sv
// constants, field layouts and carriers of the wake-event indirect register bank
// ==========================================================================
package wake_event_pkg;

  // ========================================================================
  // direct register numbers of the management port
  localparam logic [7:0] ADDR_CTRL0 = 8'h6E;
  localparam logic [7:0] ADDR_CTRL1 = 8'h6F;
  localparam logic [7:0] ADDR_DATA = 8'hA0;

  // ========================================================================
  // first control byte fields
  localparam int FN_MSB = 7;
  localparam int FN_LSB = 5;
  localparam logic [2:0] FN_WAKE = 3'h4;
  localparam int OP_READ_BIT = 4;
  localparam logic [3:0] SEL_GLOBAL = 4'h0;
  localparam int PORT_COUNT = 4;
  localparam logic [3:0] SEL_LAST_PORT = 4'h4;

  // ========================================================================
  // indirect byte offsets
  localparam logic [7:0] OFF_WORD_FIRST = 8'h00;
  localparam logic [7:0] OFF_WORD_LAST = 8'h03;
  localparam logic [7:0] OFF_MASK_FIRST = 8'h04;
  localparam logic [7:0] OFF_MASK_LAST = 8'h07;
  localparam int OFF_MASK_BIT = 2;

  // ========================================================================
  // field positions and reset values
  localparam int GLB_EN_BIT = 1;
  localparam int GLB_POL_BIT = 0;
  localparam int EV_MAGIC_BIT = 2;
  localparam int EV_LINK_BIT = 1;
  localparam int EV_ENERGY_BIT = 0;
  localparam logic [1:0] GLB_RESET = 2'h0;
  localparam logic [2:0] EV_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // one port's wake events, also the layout of its flag and mask fields
  typedef struct packed {
    logic magic;
    logic link_up;
    logic energy;
  } wake_ev_s;

  // one management port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

//--- tb/wake_host_model.sv
// host model that reaches the wake-event bank through the indirect registers
module wake_host_model
  import wake_event_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output reg_req_s req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req_o = '0;

  // ==========================================================================
  // one strobed access: set just after an edge, held across the edge that takes it;
  // accesses run back to back and idle() closes a burst
  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] data);
    req_o = '{wr: !rd, rd: rd, addr: addr, wdata: data};
    @(posedge mclk_i);
    #1;
  endtask

  // a released bus shows inverted values, never the old ones
  task automatic idle();
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
  endtask

  // picks the wake function, direction and set, then loads the byte offset
  task automatic select(input logic rd, input logic [3:0] sel, input logic [7:0] off);
    access(1'b0, ADDR_CTRL0, {FN_WAKE, rd, sel});
    access(1'b0, ADDR_CTRL1, off);
  endtask

  task automatic ind_wr(input logic [3:0] sel, input logic [7:0] off, input logic [7:0] data);
    select(1'b0, sel, off);
    access(1'b0, ADDR_DATA, data);
    idle();
  endtask

  // read data stands just after the edge that takes the read strobe
  task automatic ind_rd(input logic [3:0] sel, input logic [7:0] off, output logic [7:0] data);
    select(1'b1, sel, off);
    access(1'b1, ADDR_DATA, 8'h00);
    data = rdata_i;
    idle();
  endtask
endmodule

//--- tb/wake_event_indirect_regs_tb_top.sv
// self-checking bench of the wake-event indirect register bank
module wake_event_indirect_regs_tb_top;
  import wake_event_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  reg_req_s req;
  wake_ev_s [PORT_COUNT-1:0] ev = '0;
  logic [7:0] rdata;
  logic wake;
  int n_errors = 0;
  int samples_checked = 0;

  // ==========================================================================
  // clock and design
  always #20 mclk = ~mclk;

  wake_event_indirect_regs u_wake_event_indirect_regs (
    .MCLK_I(mclk),
    .RST_I(rst),
    .REG_REQ_I(req),
    .WAKE_EV_I(ev),
    .REG_RDATA_O(rdata),
    .WAKE_O(wake)
  );

  wake_host_model u_wake_host_model (.mclk_i(mclk), .rdata_i(rdata), .req_o(req));

  // ==========================================================================
  // comparison, reporting and helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [3:0] sel, input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] v;
    u_wake_host_model.ind_rd(sel, off, v);
    check(v, exp);
  endtask

  task automatic wr(input logic [3:0] sel, input logic [7:0] off, input logic [7:0] data);
    u_wake_host_model.ind_wr(sel, off, data);
  endtask

  // the pin settles two edges after the write or the event that moves it
  task automatic pin_chk(input logic [7:0] exp);
    repeat (2) @(posedge mclk);
    #1;
    check({7'h00, wake}, exp);
  endtask

  // one-cycle event pulse on one port
  task automatic pulse(input int p, input int b);
    @(posedge mclk);
    #1;
    ev[p][b] = 1'b1;
    @(posedge mclk);
    #1;
    ev[p][b] = 1'b0;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    check({7'h00, wake}, 8'h01);
    rst = 1'b0;
    // reset values of every byte of the global word and of port 1, reserved ones included
    for (int o = 0; o < 8; o++) begin
      rd_chk(SEL_GLOBAL, 8'(o), 8'h00);
      rd_chk(4'h1, 8'(o), 8'h00);
    end
    wr(SEL_GLOBAL, OFF_WORD_FIRST, 8'hFF);
    wr(SEL_GLOBAL, OFF_WORD_LAST, 8'hFF);
    rd_chk(SEL_GLOBAL, OFF_WORD_FIRST, 8'h00);
    rd_chk(SEL_GLOBAL, OFF_WORD_LAST, 8'h03);
    pin_chk(8'h00);
    // every event of every port: latch, mask, write-0, write-1 clear
    for (int p = 0; p < PORT_COUNT; p++) begin
      for (int b = 0; b < 3; b++) begin
        pulse(p, b);
        pin_chk(8'h00);
        rd_chk(4'(p + 1), OFF_WORD_LAST, 8'(1 << b));
        wr(4'(p + 1), OFF_MASK_LAST, 8'(1 << b));
        rd_chk(4'(p + 1), OFF_MASK_LAST, 8'(1 << b));
        pin_chk(8'h01);
        wr(4'(p + 1), OFF_WORD_LAST, 8'h00);
        rd_chk(4'(p + 1), OFF_WORD_LAST, 8'(1 << b));
        wr(4'(p + 1), OFF_WORD_LAST, 8'(1 << b));
        pin_chk(8'h00);
        wr(4'(p + 1), OFF_MASK_LAST, 8'h00);
      end
    end
    // active-low drive, then disabled pin idles high
    wr(SEL_GLOBAL, OFF_WORD_LAST, 8'h02);
    pulse(0, 0);
    wr(4'h1, OFF_MASK_LAST, 8'h01);
    pin_chk(8'h00);
    wr(SEL_GLOBAL, OFF_WORD_LAST, 8'h00);
    pin_chk(8'h01);
    // refused selections and offsets
    rd_chk(4'h5, OFF_WORD_LAST, 8'h00);
    rd_chk(4'h1, 8'h08, 8'h00);
    // control bytes read back as the read above left them
    u_wake_host_model.access(1'b1, ADDR_CTRL0, 8'h00);
    check(rdata, {FN_WAKE, 1'b1, 4'h1});
    u_wake_host_model.access(1'b1, ADDR_CTRL1, 8'h00);
    check(rdata, 8'h08);
    u_wake_host_model.idle();
    rd_chk(4'h1, 8'h02, 8'h00);
    // port 5 must not alias onto port 1, nor a non-last mask byte land
    wr(4'h5, OFF_MASK_LAST, 8'h06);
    wr(4'h1, OFF_MASK_FIRST, 8'h06);
    rd_chk(4'h1, OFF_MASK_LAST, 8'h01);
    // a data write while read mode is selected reaches no wake register
    u_wake_host_model.access(1'b0, ADDR_DATA, 8'h06);
    u_wake_host_model.idle();
    rd_chk(4'h1, OFF_MASK_LAST, 8'h01);
    wr(4'h1, OFF_MASK_LAST, 8'hFF);
    rd_chk(4'h1, OFF_MASK_LAST, 8'h07);
    // a held event beats a write-1 clear in the same cycle
    ev[1].energy = 1'b1;
    wr(4'h2, OFF_WORD_LAST, 8'h01);
    rd_chk(4'h2, OFF_WORD_LAST, 8'h01);
    ev[1].energy = 1'b0;
    wr(4'h2, OFF_WORD_LAST, 8'h01);
    rd_chk(4'h2, OFF_WORD_LAST, 8'h00);
    u_wake_host_model.access(1'b1, 8'h55, 8'h00);
    u_wake_host_model.idle();
    check(rdata, 8'h00);
    // a second reset in mid-run restores every register
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    check({7'h00, wake}, 8'h01);
    rd_chk(4'h1, OFF_MASK_LAST, 8'h00);
    rd_chk(4'h1, OFF_WORD_LAST, 8'h00);
    close_out();
  end

  // bound on the whole run
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    close_out();
  end
endmodule
